// File: hdl/powercomm_pkg.sv
// constants and types shared by the power receiver communication sequencer
// Function
// [R1] send receiver data by switching coil capacitors at 2 kbps
// [R2] recover transmitter data from power signal frequency shifts, use it for handshake
// [R3] packet order: preamble, header, message, checksum
// [R4] outgoing bits use bi-phase differential encoding from a 2 kHz bit clock
// [R5] one: two narrow transitions per bit; zero: one wide transition per bit
// [R6] each packet byte travels as an 11-bit asynchronous character
// [R7] character: start zero, eight data bits lsb first, odd parity, stop one
// [R8] phases: selection, ping, id and config, negotiation, calibration, power transfer
// [R9] leave selection only once rectified supply is above undervoltage lockout
// [R10] first packet in ping is signal strength, keeping transmitter power on
// [R11] after signal strength, go to identification and configuration packets
// [R12] end-of-power sent in ping keeps the sequencer in ping
// [R13] negotiation: send request, transmitter accepts or rejects
// [R14] calibration reports received power to the transmitter
// [R15] power transfer sends control error, rectified power; ends with end power packet
// [R16] re-negotiation may start during power transfer and may end early unchanged
// [R17] on load end disable regulator, repeat end-of-power until power stops or lockout
// [R18] status pins optionally show charge complete and charge fault
// [R19] four modulation switch outputs follow the modulation signal
// [R20] control error asks higher frequency above target, lower below
package powercomm_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_PERIOD_NS = 500000;
    localparam int BIT_CYCLES_DEF = BIT_PERIOD_NS / CLK_PERIOD_NS;
    localparam int NEG_WAIT_NS = 20000000;
    localparam int NEG_WAIT_CYCLES_DEF = NEG_WAIT_NS / CLK_PERIOD_NS;
    localparam int POWER_LOSS_NS = 1000000;
    localparam int POWER_LOSS_CYCLES_DEF = POWER_LOSS_NS / CLK_PERIOD_NS;
    localparam int PREAMBLE_BITS_DEF = 11;
    localparam int FSK_HOLD_DEF = 8;
    localparam logic [15:0] FSK_DELTA_DEF = 16'h0004;
    localparam int CHAR_BITS = 11;
    localparam int PKT_BYTES = 3;

    localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01;
    localparam logic [7:0] HDR_END_POWER = 8'h02;
    localparam logic [7:0] HDR_CTRL_ERROR = 8'h03;
    localparam logic [7:0] HDR_RECT_POWER = 8'h04;
    localparam logic [7:0] HDR_RX_POWER = 8'h31;
    localparam logic [7:0] HDR_CONFIG = 8'h51;
    localparam logic [7:0] HDR_NEG_REQ = 8'h20;
    localparam logic [7:0] HDR_IDENT = 8'h71;
    localparam logic [7:0] EPT_CHARGE_DONE = 8'h01;

    typedef enum logic [7:0] {
        PH_SELECTION = 8'h01,
        PH_PING = 8'h02,
        PH_ID_CFG = 8'h04,
        PH_NEGOTIATE = 8'h08,
        PH_CALIBRATE = 8'h10,
        PH_POWER_XFER = 8'h20,
        PH_RENEGOTIATE = 8'h40,
        PH_END_POWER = 8'h80
    } phase_type;
endpackage

// File: hdl/power_comm_sequencer.sv
// receiver phase sequencer with load-modulation packet sender and fsk demodulator
`timescale 1ns/1ps
module power_comm_sequencer #(
    parameter int BIT_CYCLES = powercomm_pkg::BIT_CYCLES_DEF,
    parameter int NEG_WAIT_CYCLES = powercomm_pkg::NEG_WAIT_CYCLES_DEF,
    parameter int POWER_LOSS_CYCLES = powercomm_pkg::POWER_LOSS_CYCLES_DEF,
    parameter int PREAMBLE_BITS = powercomm_pkg::PREAMBLE_BITS_DEF,
    parameter int FSK_HOLD = powercomm_pkg::FSK_HOLD_DEF,
    parameter logic [15:0] FSK_DELTA = powercomm_pkg::FSK_DELTA_DEF,
    parameter logic [7:0] IDENT_BYTE = 8'h5a,
    parameter logic [7:0] CONFIG_BYTE = 8'h0a
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic uvlo_ok_pin,
    input wire logic fsk_sense_pin,
    input wire logic load_request,
    input wire logic reneg_request,
    input wire logic reneg_abort,
    input wire logic [11:0] vrect_sample,
    input wire logic [11:0] vrect_target,
    input wire logic [7:0] signal_strength,
    input wire logic [7:0] rect_power,
    input wire logic [7:0] rx_power,
    input wire logic charge_done,
    input wire logic charge_fault,
    input wire logic [2:0] status_enable,
    output logic mod_switch_a0,
    output logic mod_switch_a1,
    output logic mod_switch_b0,
    output logic mod_switch_b1,
    output logic ldo_enable,
    output logic neg_accepted,
    output powercomm_pkg::phase_type phase,
    output logic [2:0] status_indicator_pins
);
    import powercomm_pkg::*;

    localparam int HALF_CYCLES = BIT_CYCLES / 2;

    if (BIT_CYCLES < 4 || BIT_CYCLES % 2 != 0 || BIT_CYCLES > 65536 || PREAMBLE_BITS < 1 ||
        PREAMBLE_BITS > 32 || NEG_WAIT_CYCLES < 1 || NEG_WAIT_CYCLES > 16777215 ||
        POWER_LOSS_CYCLES < 2 || POWER_LOSS_CYCLES > 65535 || FSK_HOLD < 1 ||
        FSK_HOLD > 255) begin : g_bad_param
        $error("parameter outside what the counters serve");
    end

    // start zero, data lsb first, odd parity, stop one; shifted out from bit 0
    function automatic logic [10:0] frame_char(input logic [7:0] data);
        frame_char = {1'b1, ~(^data), data, 1'b0}; // R6 R7
    endfunction

    // clipped signed error; negative (above target) asks higher frequency
    function automatic logic [7:0] ctrl_error(input logic [11:0] target, input logic [11:0] meas);
        logic signed [12:0] diff;
        diff = $signed({1'b0, target}) - $signed({1'b0, meas});
        ctrl_error = (diff > 13'sd127) ? 8'h7f : (diff < -13'sd128) ? 8'h80 : diff[7:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic uvlo_meta_r, uvlo_ok_r;
    logic fsk_meta_r, fsk_sync_r, fsk_prev_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {uvlo_meta_r, uvlo_ok_r, fsk_meta_r, fsk_sync_r, fsk_prev_r} <= 5'h00;
        end else begin
            {uvlo_ok_r, uvlo_meta_r} <= {uvlo_meta_r, uvlo_ok_pin};
            {fsk_prev_r, fsk_sync_r, fsk_meta_r} <= {fsk_sync_r, fsk_meta_r, fsk_sense_pin};
        end
    end
    wire fsk_rise = fsk_sync_r & ~fsk_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // fsk demodulation: period of the power signal against a captured base period
    logic [15:0] period_cnt_r, base_period_r;
    logic base_valid_r, power_present_r, fsk_ack_r;
    logic [7:0] hold_cnt_r;
    phase_type state_r;
    wire [15:0] period_diff = (period_cnt_r > base_period_r) ?
        period_cnt_r - base_period_r : base_period_r - period_cnt_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            period_cnt_r <= 16'h0000;
            base_period_r <= 16'h0000;
            {base_valid_r, power_present_r, fsk_ack_r} <= 3'h0;
            hold_cnt_r <= 8'h00;
        end else if (fsk_rise) begin
            period_cnt_r <= 16'h0001;
            power_present_r <= 1'b1;
            if (state_r == PH_SELECTION || !base_valid_r) begin
                // base taken before any shift is expected
                base_period_r <= period_cnt_r;
                base_valid_r <= power_present_r;
                hold_cnt_r <= 8'h00;
                fsk_ack_r <= 1'b0;
            end else if (period_diff > FSK_DELTA) begin // R2
                if (hold_cnt_r == 8'(FSK_HOLD - 1)) begin
                    fsk_ack_r <= 1'b1;
                end else begin
                    hold_cnt_r <= hold_cnt_r + 8'h01;
                end
            end else begin
                hold_cnt_r <= 8'h00;
                fsk_ack_r <= 1'b0;
            end
        end else if (period_cnt_r == 16'(POWER_LOSS_CYCLES - 1)) begin
            // no edges for too long: transmitter has removed power
            power_present_r <= 1'b0;
            base_valid_r <= 1'b0;
            fsk_ack_r <= 1'b0;
            hold_cnt_r <= 8'h00;
        end else begin
            period_cnt_r <= period_cnt_r + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // packet sender: preamble ones, then header, message, checksum characters
    logic tx_go_r, tx_busy_r, tx_done_r, half_r, in_pre_r, mod_r;
    logic [7:0] tx_hdr_r, tx_msg_r;
    logic [7:0] pkt_bytes_r [PKT_BYTES];
    logic [15:0] half_cnt_r;
    logic [4:0] pre_cnt_r;
    logic [10:0] frm_r;
    logic [3:0] bit_idx_r;
    logic [1:0] byte_idx_r;
    wire half_tick = tx_busy_r && half_cnt_r == 16'(HALF_CYCLES - 1); // R4
    wire cur_bit = in_pre_r | frm_r[0];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {tx_busy_r, tx_done_r, half_r, in_pre_r, mod_r} <= 5'h00;
            half_cnt_r <= 16'h0000;
            pre_cnt_r <= 5'h00;
            frm_r <= 11'h000;
            bit_idx_r <= 4'h0;
            byte_idx_r <= 2'h0;
            for (int i = 0; i < PKT_BYTES; i++) begin
                pkt_bytes_r[i] <= 8'h00;
            end
        end else begin
            tx_done_r <= 1'b0;
            if (!uvlo_ok_r) begin
                tx_busy_r <= 1'b0;
                mod_r <= 1'b0;
            end else if (tx_go_r && !tx_busy_r) begin
                pkt_bytes_r[0] <= tx_hdr_r; // R3
                pkt_bytes_r[1] <= tx_msg_r;
                pkt_bytes_r[2] <= tx_hdr_r ^ tx_msg_r;
                tx_busy_r <= 1'b1;
                half_cnt_r <= 16'h0000;
                half_r <= 1'b0;
                in_pre_r <= 1'b1;
                pre_cnt_r <= 5'h00;
                mod_r <= ~mod_r; // R4
            end else if (tx_busy_r) begin
                half_cnt_r <= half_tick ? 16'h0000 : half_cnt_r + 16'h0001;
                if (half_tick && !half_r) begin
                    half_r <= 1'b1;
                    // mid-bit transition only for a one
                    if (cur_bit) begin
                        mod_r <= ~mod_r; // R5
                    end
                end else if (half_tick) begin
                    half_r <= 1'b0;
                    mod_r <= ~mod_r; // R5
                    if (in_pre_r) begin
                        if (pre_cnt_r == 5'(PREAMBLE_BITS - 1)) begin
                            in_pre_r <= 1'b0;
                            frm_r <= frame_char(pkt_bytes_r[0]); // R6
                            bit_idx_r <= 4'h0;
                            byte_idx_r <= 2'h0;
                        end else begin
                            pre_cnt_r <= pre_cnt_r + 5'h01;
                        end
                    end else if (bit_idx_r != 4'(CHAR_BITS - 1)) begin
                        frm_r <= {1'b0, frm_r[10:1]}; // R7
                        bit_idx_r <= bit_idx_r + 4'h1;
                    end else if (byte_idx_r != 2'(PKT_BYTES - 1)) begin
                        frm_r <= frame_char(pkt_bytes_r[byte_idx_r + 2'h1]);
                        bit_idx_r <= 4'h0;
                        byte_idx_r <= byte_idx_r + 2'h1;
                    end else begin
                        // packet over: switches released
                        tx_busy_r <= 1'b0;
                        tx_done_r <= 1'b1;
                        mod_r <= 1'b0;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {mod_switch_a0, mod_switch_a1, mod_switch_b0, mod_switch_b1} <= 4'h0;
        end else begin
            {mod_switch_a0, mod_switch_a1, mod_switch_b0, mod_switch_b1} <= {4{mod_r}}; // R19 R1
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer
    logic sent_r, sub_r, wait_r;
    logic [23:0] wait_cnt_r;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_r <= PH_SELECTION;
            {sent_r, sub_r, wait_r, tx_go_r} <= 4'h0;
            wait_cnt_r <= 24'h000000;
            tx_hdr_r <= 8'h00;
            tx_msg_r <= 8'h00;
            neg_accepted <= 1'b0;
        end else begin
            tx_go_r <= 1'b0;
            if (!uvlo_ok_r) begin
                state_r <= PH_SELECTION; // R9 R17
                sent_r <= 1'b0;
                sub_r <= 1'b0;
                wait_r <= 1'b0;
            end else begin
                if (tx_done_r) begin
                    sent_r <= 1'b0;
                end
                case (state_r)
                    PH_SELECTION: begin
                        state_r <= PH_PING; // R9 R8
                    end
                    PH_PING: begin
                        if (!sent_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= load_request ? HDR_SIG_STRENGTH : HDR_END_POWER; // R10
                            tx_msg_r <= load_request ? signal_strength : EPT_CHARGE_DONE;
                        end else if (tx_done_r && tx_hdr_r == HDR_SIG_STRENGTH) begin
                            state_r <= PH_ID_CFG; // R11
                        end
                        // an end-of-power packet leaves the phase unchanged R12
                    end
                    PH_ID_CFG: begin
                        if (!sent_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= sub_r ? HDR_CONFIG : HDR_IDENT; // R11
                            tx_msg_r <= sub_r ? CONFIG_BYTE : IDENT_BYTE;
                        end else if (tx_done_r) begin
                            sub_r <= ~sub_r;
                            if (sub_r) begin
                                state_r <= PH_NEGOTIATE; // R8
                            end
                        end
                    end
                    PH_NEGOTIATE, PH_RENEGOTIATE: begin
                        if (state_r == PH_RENEGOTIATE && reneg_abort) begin
                            // early exit keeps the present transmit power R16
                            state_r <= PH_POWER_XFER;
                            wait_r <= 1'b0;
                        end else if (!sent_r && !wait_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= HDR_NEG_REQ; // R13
                            tx_msg_r <= CONFIG_BYTE;
                        end else if (tx_done_r) begin
                            wait_r <= 1'b1;
                            wait_cnt_r <= 24'h000000;
                        end else if (wait_r) begin
                            wait_cnt_r <= wait_cnt_r + 24'h000001;
                            // shifted frequency held: accept; silence to timeout: reject
                            if (fsk_ack_r || wait_cnt_r == 24'(NEG_WAIT_CYCLES - 1)) begin
                                neg_accepted <= fsk_ack_r; // R13 R2
                                wait_r <= 1'b0;
                                state_r <= (state_r == PH_NEGOTIATE) ?
                                    PH_CALIBRATE : PH_POWER_XFER; // R8
                            end
                        end
                    end
                    PH_CALIBRATE: begin
                        if (!sent_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= HDR_RX_POWER; // R14
                            tx_msg_r <= rx_power;
                        end else if (tx_done_r) begin
                            state_r <= PH_POWER_XFER; // R8
                        end
                    end
                    PH_POWER_XFER: begin
                        if (!sent_r && !load_request) begin
                            state_r <= PH_END_POWER; // R15 R17
                        end else if (!sent_r && reneg_request) begin
                            state_r <= PH_RENEGOTIATE; // R16
                        end else if (!sent_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= sub_r ? HDR_RECT_POWER : HDR_CTRL_ERROR; // R15
                            tx_msg_r <= sub_r ? rect_power :
                                ctrl_error(vrect_target, vrect_sample); // R20
                        end else if (tx_done_r) begin
                            sub_r <= ~sub_r;
                        end
                    end
                    PH_END_POWER: begin
                        // finish the packet in flight, or ping would miss its start
                        if (!power_present_r && !sent_r) begin
                            state_r <= PH_SELECTION; // R17
                            sent_r <= 1'b0;
                            sub_r <= 1'b0;
                        end else if (!sent_r) begin
                            sent_r <= 1'b1;
                            tx_go_r <= 1'b1;
                            tx_hdr_r <= HDR_END_POWER; // R15 R17
                            tx_msg_r <= EPT_CHARGE_DONE;
                        end
                    end
                    default: begin
                        state_r <= PH_SELECTION;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // regulator enable, phase and status pins
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ldo_enable <= 1'b0;
            phase <= PH_SELECTION;
            status_indicator_pins <= 3'h0;
        end else begin
            ldo_enable <= (state_r == PH_POWER_XFER || state_r == PH_RENEGOTIATE); // R17
            phase <= state_r;
            status_indicator_pins <= status_enable &
                {ldo_enable, charge_fault, charge_done}; // R18
        end
    end
endmodule

// File: dv/power_comm_sequencer_properties.sv
// port-level assertions for the power receiver communication sequencer
`timescale 1ns/1ps
module power_comm_sequencer_checker (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic uvlo_ok_pin,
    input wire logic charge_done,
    input wire logic charge_fault,
    input wire logic [2:0] status_enable,
    input wire logic mod_switch_a0,
    input wire logic mod_switch_a1,
    input wire logic mod_switch_b0,
    input wire logic mod_switch_b1,
    input wire logic ldo_enable,
    input wire logic neg_accepted,
    input wire powercomm_pkg::phase_type phase,
    input wire logic [2:0] status_indicator_pins
);
    import powercomm_pkg::*;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    a_switch_equal: assert property (
        {mod_switch_a1, mod_switch_b0, mod_switch_b1} == {3{mod_switch_a0}})
        else $error("modulation switches disagree");
    // rises only: the forced idle level may sit close to the next packet
    a_half_bit_hold: assert property (disable iff (rst || !uvlo_ok_pin)
        $rose(mod_switch_a0) |=> $stable(mod_switch_a0)[*8]) else $error("half bit too short");
    a_lockout_idle: assert property (!uvlo_ok_pin [*6] |->
        phase == PH_SELECTION && !mod_switch_a0) else $error("active below lockout");
    a_ping_entry: assert property ($rose(phase == PH_PING) |->
        $past(phase) == PH_SELECTION) else $error("ping not entered from selection");
    a_idcfg_entry: assert property ($rose(phase == PH_ID_CFG) |->
        $past(phase) == PH_PING) else $error("identification not entered from ping");
    a_cal_entry: assert property ($rose(phase == PH_CALIBRATE) |->
        $past(phase) == PH_NEGOTIATE) else $error("calibration not after negotiation");
    a_xfer_entry: assert property ($rose(phase == PH_POWER_XFER) |->
        $past(phase) inside {PH_CALIBRATE, PH_RENEGOTIATE}) else $error("bad transfer entry");
    a_ldo_in_xfer: assert property ((phase == PH_POWER_XFER)[*2] |-> ldo_enable)
        else $error("regulator off in transfer");
    a_ldo_off_end: assert property ((phase == PH_END_POWER)[*2] |-> !ldo_enable)
        else $error("regulator on in end of power");
    a_status_mirror: assert property (status_indicator_pins[1:0] == $past(
        {charge_fault & status_enable[1], charge_done & status_enable[0]}))
        else $error("status pins wrong");
    c_xfer: cover property (phase == PH_POWER_XFER);
    c_reneg: cover property (phase == PH_RENEGOTIATE);
    c_accept: cover property ($rose(neg_accepted));
endmodule

bind power_comm_sequencer power_comm_sequencer_checker checker_i (.sys_clk, .rst, .uvlo_ok_pin,
    .charge_done, .charge_fault, .status_enable, .mod_switch_a0, .mod_switch_a1, .mod_switch_b0,
    .mod_switch_b1, .ldo_enable, .neg_accepted, .phase, .status_indicator_pins);

// File: dv/tx_partner_model.sv
// transmitter stand-in: fsk power signal source and load-modulation packet decoder
`timescale 1ns/1ps
module tx_partner_model #(
    parameter int BITS = 20,
    parameter int PRE = 4
) (
    input wire logic sys_clk,
    input wire logic mod_level,
    input wire logic power_on,
    input wire logic ack_shift,
    output logic fsk_sense_pin,
    output logic [7:0] hdr,
    output logic [7:0] msg,
    output logic frame_ok,
    output int pkt_cnt
);
    logic [7:0] chr [3];
    logic l1, l2, prev, bit_v, ok;
    int j;
    initial begin
        fsk_sense_pin = 1'b0;
        pkt_cnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // longer period marks an accept; without power the pin stands still
    always begin
        repeat (ack_shift ? 9 : 6) @(posedge sys_clk);
        fsk_sense_pin <= power_on & ~fsk_sense_pin;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // half bits sampled mid-way: a cycle of edge jitter is harmless
    always begin
        @(posedge mod_level);
        ok = 1'b1;
        for (int k = 0; k < PRE + 33; k++) begin
            repeat (BITS / 4) @(posedge sys_clk);
            l1 = mod_level;
            repeat (BITS / 2) @(posedge sys_clk);
            l2 = mod_level;
            repeat (BITS / 4) @(posedge sys_clk);
            bit_v = l1 ^ l2;
            if (k > 0 && l1 == prev) ok = 1'b0;
            prev = l2;
            j = k - PRE;
            if (k < PRE) ok &= bit_v;
            else if (j % 11 == 0) ok &= ~bit_v;
            else if (j % 11 < 9) chr[j / 11][j % 11 - 1] = bit_v;
            else if (j % 11 == 9) ok &= ^{chr[j / 11], bit_v};
            else ok &= bit_v;
        end
        hdr = chr[0];
        msg = chr[1];
        frame_ok = ok & (chr[2] == (chr[0] ^ chr[1]));
        pkt_cnt++;
    end
endmodule

// File: dv/power_comm_sequencer_tb_top.sv
// self-checking bench for the power receiver sequencer
`timescale 1ns/1ps
module power_comm_sequencer_tb_top;
    import powercomm_pkg::*;
    localparam int BC = 20, PB = 4;
    logic sys_clk = 1'b0, rst = 1'b1, uvlo_ok_pin = 1'b0, load_request = 1'b0;
    logic reneg_request = 1'b0, reneg_abort = 1'b0, charge_done = 1'b0, charge_fault = 1'b0;
    logic power_on = 1'b1, ack_shift = 1'b0;
    logic [11:0] vrect_sample = 12'h810, vrect_target = 12'h800;
    logic [7:0] signal_strength = 8'h3c, rect_power = 8'h77, rx_power = 8'h42;
    logic [2:0] status_enable = 3'h0, status_indicator_pins;
    logic fsk_sense_pin, mod_switch_a0, mod_switch_a1, mod_switch_b0, mod_switch_b1;
    logic ldo_enable, neg_accepted, frame_ok;
    logic [7:0] hdr, msg;
    logic [11:0] smp [3] = '{12'h7f0, 12'h000, 12'hfff};
    logic [7:0] err [3] = '{8'h10, 8'h7f, 8'h80};
    phase_type phase;
    int pkt_cnt, seen = 0, mismatches = 0, n_tests = 0;

    power_comm_sequencer #(.BIT_CYCLES(BC), .NEG_WAIT_CYCLES(200), .POWER_LOSS_CYCLES(100),
        .PREAMBLE_BITS(PB), .IDENT_BYTE(8'h3e), .CONFIG_BYTE(8'h0b)) power_comm_sequencer_i (
        .sys_clk, .rst, .uvlo_ok_pin, .fsk_sense_pin, .load_request, .reneg_request,
        .reneg_abort, .vrect_sample, .vrect_target, .signal_strength, .rect_power, .rx_power,
        .charge_done, .charge_fault, .status_enable, .mod_switch_a0, .mod_switch_a1,
        .mod_switch_b0, .mod_switch_b1, .ldo_enable, .neg_accepted, .phase, .status_indicator_pins);
    tx_partner_model #(.BITS(BC), .PRE(PB)) tx_partner_model_i (.sys_clk,
        .mod_level(mod_switch_a0), .power_on, .ack_shift, .fsk_sense_pin, .hdr, .msg, .frame_ok,
        .pkt_cnt);

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_phase(input phase_type p);
        int i;
        for (i = 0; i < 3000 && phase !== p; i++) @(negedge sys_clk);
        if (i == 3000) begin
            mismatches++;
            complete_run();
        end
        repeat (2) @(negedge sys_clk);
    endtask
    task automatic next_pkt();
        int i;
        for (i = 0; i < 3000 && pkt_cnt == seen; i++) @(negedge sys_clk);
        if (i == 3000) begin
            mismatches++;
            complete_run();
        end
        seen = pkt_cnt;
        check(frame_ok, 1'b1);
    endtask
    task automatic pkt(input logic [7:0] h, input logic [7:0] m);
        next_pkt();
        check(hdr, h);
        check(msg, m);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_startup();
        repeat (50) @(negedge sys_clk);
        check(phase, PH_SELECTION);
        check(mod_switch_a0, 1'b0);
        uvlo_ok_pin = 1'b1;
        wait_phase(PH_PING);
        pkt(HDR_END_POWER, EPT_CHARGE_DONE);
        check(phase, PH_PING);
        load_request = 1'b1;
        next_pkt();
        if (hdr === HDR_END_POWER) next_pkt();
        check(hdr, HDR_SIG_STRENGTH);
        check(msg, signal_strength);
        wait_phase(PH_ID_CFG);
        $display("startup done");
    endtask
    task automatic t_setup();
        pkt(HDR_IDENT, 8'h3e);
        pkt(HDR_CONFIG, 8'h0b);
        wait_phase(PH_NEGOTIATE);
        pkt(HDR_NEG_REQ, 8'h0b);
        ack_shift = 1'b1;
        wait_phase(PH_CALIBRATE);
        ack_shift = 1'b0;
        check(neg_accepted, 1'b1);
        pkt(HDR_RX_POWER, rx_power);
        wait_phase(PH_POWER_XFER);
        check(ldo_enable, 1'b1);
        $display("setup done");
    endtask
    task automatic t_transfer();
        pkt(HDR_CTRL_ERROR, 8'hf0);
        for (int i = 0; i < 3; i++) begin
            vrect_sample = smp[i];
            pkt(HDR_RECT_POWER, rect_power);
            pkt(HDR_CTRL_ERROR, err[i]);
        end
        charge_done = 1'b1;
        charge_fault = 1'b1;
        status_enable = 3'b101;
        repeat (3) @(negedge sys_clk);
        check(status_indicator_pins, 3'b101);
        status_enable = 3'b110;
        repeat (3) @(negedge sys_clk);
        check(status_indicator_pins, 3'b110);
        $display("transfer done");
    endtask
    task automatic t_reneg(input logic abort);
        reneg_request = 1'b1;
        wait_phase(PH_RENEGOTIATE);
        reneg_request = 1'b0;
        seen = pkt_cnt;
        pkt(HDR_NEG_REQ, 8'h0b);
        reneg_abort = abort;
        if (abort) repeat (3) @(negedge sys_clk);
        else wait_phase(PH_POWER_XFER);
        check(phase, PH_POWER_XFER);
        reneg_abort = 1'b0;
        seen = pkt_cnt;
        check(neg_accepted, abort);
        check(ldo_enable, 1'b1);
        $display("reneg done");
    endtask
    task automatic t_end();
        load_request = 1'b0;
        wait_phase(PH_END_POWER);
        check(ldo_enable, 1'b0);
        seen = pkt_cnt;
        pkt(HDR_END_POWER, EPT_CHARGE_DONE);
        pkt(HDR_END_POWER, EPT_CHARGE_DONE);
        check(phase, PH_END_POWER);
        power_on = 1'b0;
        wait_phase(PH_PING);
        uvlo_ok_pin = 1'b0;
        wait_phase(PH_SELECTION);
        repeat (5) @(negedge sys_clk);
        check(mod_switch_a0, 1'b0);
        $display("end done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_startup();
        t_setup();
        t_transfer();
        t_reneg(1'b1);
        t_reneg(1'b0);
        t_end();
        complete_run();
    end
endmodule
